// ==== hw/lgc_params.svh ====
// register offsets, field positions, reset values and timing counts of the bank
`ifndef LGC_PARAMS_SVH
`define LGC_PARAMS_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define LGC_CH_STRIDE 8'h10
`define LGC_OFF_IRQ_EN 4'h4
`define LGC_OFF_IRQ_STAT 4'h6
`define LGC_OFF_SEG5 4'hc
`define LGC_OFF_SEG6 4'hd
`define LGC_OFF_SEG7 4'he
`define LGC_OFF_SEG8 4'hf
`define LGC_ADDR_LINE_CFG 8'he0
`define LGC_ADDR_LOS_ACT 8'he1

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define LGC_SEG_MASK 8'h7f
`define LGC_SEG_SIGN 6
`define LGC_RAIL_FMT 7
`define LGC_AUTO_AOS 6
`define LGC_RX_EDGE 5
`define LGC_TX_EDGE 4
`define LGC_POL 3
`define LGC_GIE 1
`define LGC_SRST 0
`define LGC_MUTE 2
`define LGC_LOS_IRQ_BIT 1
`define LGC_LINE_CFG_RST 8'h00
`define LGC_LOS_ACT_RST 1'b0
`define LGC_SEG_RST 7'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LGC_CLK_PERIOD_NS 8
`define LGC_SRST_MIN_NS 10000
`define LGC_SRST_CYC ((`LGC_SRST_MIN_NS + `LGC_CLK_PERIOD_NS - 1) / `LGC_CLK_PERIOD_NS)

`endif

// ==== hw/lgc_pkg.sv ====
// types shared by the configuration bank
package lgc_pkg;

  typedef logic [7:0] lgc_byte_t;

  // soft reset sequencer, one-hot
  typedef enum logic [2:0] {
    LGC_RUN = 3'b001,
    LGC_ARM = 3'b010,
    LGC_HOLD = 3'b100
  } lgc_srst_e;

endpackage : lgc_pkg

// ==== hw/lgc_sync.sv ====
// two flip-flop synchroniser for a vector of pin inputs
module lgc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import lgc_pkg::*;

  logic [W-1:0] meta_reg;

  // first stage read only by second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : lgc_sync

// ==== hw/lgc_rail_cap.sv ====
// captures a pair of rails on the chosen edge of a sampled line clock
module lgc_rail_cap #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // internal clear
  input wire logic clr,
  // line clock and edge choice
  input wire logic [W-1:0] lclk,
  input wire logic use_fall,
  // rails
  input wire logic [W-1:0] d_pos,
  input wire logic [W-1:0] d_neg,
  output logic [W-1:0] q_pos,
  output logic [W-1:0] q_neg
);
  import lgc_pkg::*;

  logic [W-1:0] lclk_dly_reg;
  wire [W-1:0] rise = lclk & ~lclk_dly_reg;
  wire [W-1:0] fall = ~lclk & lclk_dly_reg;
  wire [W-1:0] hit = use_fall ? fall : rise;

  // per-lane capture on the selected edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_dly_reg <= '0;
      q_pos <= '0;
      q_neg <= '0;
    end else if (clr) begin
      lclk_dly_reg <= lclk; // no false edge once the clear lifts
      q_pos <= '0;
      q_neg <= '0;
    end else begin
      lclk_dly_reg <= lclk;
      q_pos <= (hit & d_pos) | (~hit & q_pos);
      q_neg <= (hit & d_neg) | (~hit & q_neg);
    end
  end

endmodule : lgc_rail_cap

// ==== hw/lgc_bank.sv ====
// global line configuration and arbitrary pulse segment register bank
//
// Implementation choice: the address-and-strobe port.
`include "lgc_params.svh"

module lgc_bank #(
  parameter int NUM_CH = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire lgc_pkg::lgc_byte_t addr,
  input wire lgc_pkg::lgc_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  output lgc_pkg::lgc_byte_t rdata,
  // line status pins
  input wire logic [NUM_CH-1:0] rx_loss_of_signal,
  // receive rails
  input wire logic [NUM_CH-1:0] rx_clock,
  input wire logic [NUM_CH-1:0] rx_pos_in,
  input wire logic [NUM_CH-1:0] rx_neg_in,
  output logic [NUM_CH-1:0] rx_pos_rail,
  output logic [NUM_CH-1:0] rx_neg_rail,
  // transmit rails
  input wire logic [NUM_CH-1:0] tx_line_clock,
  input wire logic [NUM_CH-1:0] tx_pos_rail,
  input wire logic [NUM_CH-1:0] tx_neg_rail,
  output logic [NUM_CH-1:0] tx_pos_data,
  output logic [NUM_CH-1:0] tx_neg_data,
  output logic [NUM_CH-1:0] tx_all_ones,
  // pulse shaper and global controls
  output logic [4*NUM_CH-1:0] seg_positive,
  output logic rail_format_select,
  output logic soft_reset_active,
  output logic irq
);
  import lgc_pkg::*;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > 14) begin : g_bad_ch
    $error("channel count must be 1 to 14");
  end

  localparam int NSEG = 4 * NUM_CH;
  localparam logic [10:0] SRST_CYC = 11'(`LGC_SRST_CYC);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_chan(input lgc_byte_t a);
    is_chan = ({4'h0, a[7:4]} < 8'(NUM_CH));
  endfunction : is_chan

  function automatic logic [5:0] seg_index(input lgc_byte_t a);
    seg_index = {a[7:4], a[1:0]};
  endfunction : seg_index

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [6:0] seg_reg [NSEG];
  logic [NUM_CH-1:0] irq_en_reg;
  logic [NUM_CH-1:0] irq_stat_reg;
  lgc_byte_t line_cfg_reg;
  logic mute_reg;
  lgc_byte_t rdata_reg;
  logic [NUM_CH-1:0] los_dly_reg;
  logic [NUM_CH-1:0] rx_pos_reg, rx_neg_reg, tx_pos_reg, tx_neg_reg;
  logic [NUM_CH-1:0] tx_all_ones_reg;
  logic [NSEG-1:0] seg_pos_reg;
  logic irq_reg;
  lgc_srst_e srst_st_reg, srst_st_next;
  logic [10:0] srst_cnt_reg;
  logic int_rst_reg;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire [3:0] ch = addr[7:4];
  wire chan_hit = is_chan(addr);
  wire seg_hit = chan_hit && (addr[3:2] == 2'b11);
  wire en_hit = chan_hit && (addr[3:0] == `LGC_OFF_IRQ_EN);
  wire stat_hit = chan_hit && (addr[3:0] == `LGC_OFF_IRQ_STAT);
  wire cfg_hit = (addr == `LGC_ADDR_LINE_CFG);
  wire los_hit = (addr == `LGC_ADDR_LOS_ACT);
  wire [5:0] sidx = seg_index(addr);

  // named configuration bits
  wire auto_all_ones_on_los = line_cfg_reg[`LGC_AUTO_AOS];
  wire rx_clock_edge_select = line_cfg_reg[`LGC_RX_EDGE];
  wire tx_clock_edge_select = line_cfg_reg[`LGC_TX_EDGE];
  wire data_polarity_select = line_cfg_reg[`LGC_POL];
  wire global_irq_enable = line_cfg_reg[`LGC_GIE];
  wire soft_reset_bit = line_cfg_reg[`LGC_SRST];
  wire rx_mute_on_los = mute_reg;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7*NUM_CH-1:0] pins_s;

  lgc_sync #(.W(7 * NUM_CH)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({rx_loss_of_signal, rx_clock, rx_pos_in, rx_neg_in,
        tx_line_clock, tx_pos_rail, tx_neg_rail}),
    .q(pins_s)
  );

  wire [NUM_CH-1:0] los_s = pins_s[6*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] rclk_s = pins_s[5*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] rx_pos_rail_s = pins_s[4*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] rx_neg_rail_s = pins_s[3*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] tx_line_clock_s = pins_s[2*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] tx_pos_rail_s = pins_s[NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] tx_neg_rail_s = pins_s[0 +: NUM_CH];

  // ----------------------------------------------------------------
  // rail capture
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] rx_cap_pos, rx_cap_neg, tx_cap_pos, tx_cap_neg;

  lgc_rail_cap #(.W(NUM_CH)) u_rx_cap (
    .clk(clk),
    .rst_n(rst_n),
    .clr(int_rst_reg),
    .lclk(rclk_s),
    .use_fall(rx_clock_edge_select),
    .d_pos(rx_pos_rail_s),
    .d_neg(rx_neg_rail_s),
    .q_pos(rx_cap_pos),
    .q_neg(rx_cap_neg)
  );

  lgc_rail_cap #(.W(NUM_CH)) u_tx_cap (
    .clk(clk),
    .rst_n(rst_n),
    .clr(int_rst_reg),
    .lclk(tx_line_clock_s),
    .use_fall(~tx_clock_edge_select),
    .d_pos(tx_pos_rail_s),
    .d_neg(tx_neg_rail_s),
    .q_pos(tx_cap_pos),
    .q_neg(tx_cap_neg)
  );

  // polarity, mute and rail format applied to the rails
  wire [NUM_CH-1:0] pol_mask = {NUM_CH{data_polarity_select}};
  wire [NUM_CH-1:0] mute_mask = {NUM_CH{rx_mute_on_los}} & los_s;
  wire [NUM_CH-1:0] dual_mask = {NUM_CH{~rail_format_select}};
  wire [NUM_CH-1:0] rx_pos_next = (rx_cap_pos ^ pol_mask) & ~mute_mask;
  wire [NUM_CH-1:0] rx_neg_next = (rx_cap_neg ^ pol_mask) & ~mute_mask & dual_mask;
  wire [NUM_CH-1:0] tx_pos_next = tx_cap_pos ^ pol_mask;
  wire [NUM_CH-1:0] tx_neg_next = (tx_cap_neg ^ pol_mask) & dual_mask;
  wire [NUM_CH-1:0] tx_all_ones_next = {NUM_CH{auto_all_ones_on_los}} & los_s;

  // ----------------------------------------------------------------
  // line side flops, cleared while soft reset is active
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_pos_reg <= '0;
      rx_neg_reg <= '0;
      tx_pos_reg <= '0;
      tx_neg_reg <= '0;
      tx_all_ones_reg <= '0;
    end else if (int_rst_reg) begin
      rx_pos_reg <= '0;
      rx_neg_reg <= '0;
      tx_pos_reg <= '0;
      tx_neg_reg <= '0;
      tx_all_ones_reg <= '0;
    end else begin
      rx_pos_reg <= rx_pos_next;
      rx_neg_reg <= rx_neg_next;
      tx_pos_reg <= tx_pos_next;
      tx_neg_reg <= tx_neg_next;
      tx_all_ones_reg <= tx_all_ones_next;
    end
  end

  // ----------------------------------------------------------------
  // pulse segment registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NSEG; i++) begin
        seg_reg[i] <= `LGC_SEG_RST;
      end
    end else if (wr && seg_hit) begin
      seg_reg[sidx] <= wdata[6:0];
    end
  end

  // sign bit of each segment drives the shaper direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_pos_reg <= '0;
    end else begin
      for (int i = 0; i < NSEG; i++) begin
        seg_pos_reg[i] <= seg_reg[i][`LGC_SEG_SIGN];
      end
    end
  end

  // ----------------------------------------------------------------
  // global registers, untouched by soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_cfg_reg <= `LGC_LINE_CFG_RST;
      mute_reg <= `LGC_LOS_ACT_RST;
    end else if (wr && cfg_hit) begin
      line_cfg_reg <= wdata & 8'hfb;
    end else if (wr && los_hit) begin
      mute_reg <= wdata[`LGC_MUTE];
    end
  end

  // ----------------------------------------------------------------
  // channel interrupt enable and clear-on-read status
  // ----------------------------------------------------------------
  wire [NUM_CH-1:0] los_change = los_s ^ los_dly_reg;
  wire [NUM_CH-1:0] ch_sel = NUM_CH'(1) << ch;
  wire [NUM_CH-1:0] rd_clr = (rd && stat_hit) ? ch_sel : '0;
  wire [NUM_CH-1:0] stat_next = (irq_stat_reg & ~rd_clr) | los_change;
  wire irq_next = global_irq_enable && |(irq_stat_reg & irq_en_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= '0;
      irq_stat_reg <= '0;
      los_dly_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (wr && en_hit) begin
        irq_en_reg[ch] <= wdata[`LGC_LOS_IRQ_BIT];
      end
      irq_stat_reg <= stat_next;
      los_dly_reg <= los_s;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // soft reset sequencer
  // ----------------------------------------------------------------
  wire srst_done = (srst_cnt_reg == SRST_CYC - 11'd1);

  always_comb begin
    srst_st_next = srst_st_reg;
    case (srst_st_reg)
      LGC_RUN: begin
        if (soft_reset_bit) srst_st_next = LGC_ARM;
      end
      LGC_ARM: begin
        if (!soft_reset_bit) srst_st_next = LGC_RUN;
        else if (srst_done) srst_st_next = LGC_HOLD;
      end
      LGC_HOLD: begin
        if (!soft_reset_bit) srst_st_next = LGC_RUN;
      end
      default: srst_st_next = LGC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_st_reg <= LGC_RUN;
      srst_cnt_reg <= '0;
      int_rst_reg <= 1'b0;
    end else begin
      srst_st_reg <= srst_st_next;
      srst_cnt_reg <= (srst_st_reg == LGC_ARM) ? srst_cnt_reg + 11'd1 : 11'd0;
      int_rst_reg <= (srst_st_next == LGC_HOLD);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [7:0] rd_mux =
    seg_hit ? {1'b0, seg_reg[sidx]} :
    en_hit ? 8'({irq_en_reg[ch], 1'b0}) :
    stat_hit ? 8'({irq_stat_reg[ch], 1'b0}) :
    cfg_hit ? line_cfg_reg :
    los_hit ? {5'h00, mute_reg, 2'h0} :
    8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd ? rd_mux : 8'h00;
    end
  end

  // outputs
  assign rdata = rdata_reg;
  assign rx_pos_rail = rx_pos_reg;
  assign rx_neg_rail = rx_neg_reg;
  assign tx_pos_data = tx_pos_reg;
  assign tx_neg_data = tx_neg_reg;
  assign tx_all_ones = tx_all_ones_reg;
  assign seg_positive = seg_pos_reg;
  assign rail_format_select = line_cfg_reg[`LGC_RAIL_FMT];
  assign soft_reset_active = int_rst_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_seg_write;
    wr && seg_hit;
  endsequence
  sequence s_seg_readback;
    s_seg_write ##1 (rd && addr == $past(addr) && !wr);
  endsequence
  a_seg_readback: assert property (
    s_seg_readback |=> rdata == ($past(wdata, 2) & `LGC_SEG_MASK))
    else $error("segment readback mismatch");
  a_seg_top_zero: assert property (
    rd && seg_hit |=> !rdata[7])
    else $error("segment bit 7 not zero");
  a_seg_sign_out: assert property (
    s_seg_write |-> ##2 seg_positive[$past(sidx, 2)] == $past(wdata[6], 2))
    else $error("segment sign not driven");
  a_single_rail: assert property (
    rail_format_select && $stable(rail_format_select) |=> rx_neg_rail == '0)
    else $error("negative rail active in single rail");
  a_auto_ones: assert property (
    !int_rst_reg |=> tx_all_ones == ($past(tx_all_ones_next)))
    else $error("all ones not following loss of signal");
  a_mute_low: assert property (
    1'b1 |=> (rx_pos_rail & $past(mute_mask)) == '0)
    else $error("muted channel rail not low");
  a_gie_gate: assert property (
    !global_irq_enable |=> !irq)
    else $error("interrupt with global enable off");
  a_rur_clear: assert property (
    rd && stat_hit && !los_change[ch] |=> !irq_stat_reg[$past(ch)])
    else $error("status not cleared by read");
  a_srst_delay: assert property (
    $rose(int_rst_reg) |-> $past(srst_cnt_reg) == SRST_CYC - 11'd1)
    else $error("soft reset entered early");
  a_srst_keep_cfg: assert property (
    int_rst_reg && !wr |=> $stable(line_cfg_reg) && $stable(mute_reg))
    else $error("registers disturbed by soft reset");
endmodule : lgc_bank

// ==== bench/lgc_host.sv ====
// host processor model that drives the register port of the bank
module lgc_host (
  // clock
  input wire logic clk,
  // register port
  output lgc_pkg::lgc_byte_t addr,
  output lgc_pkg::lgc_byte_t wdata,
  output logic wr,
  output logic rd,
  input wire lgc_pkg::lgc_byte_t rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import lgc_pkg::*;

  // idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one write cycle; released bus shows inverted values, never stale ones
  task automatic write(input lgc_byte_t a, input lgc_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : write

  // one read cycle; data stands only in the cycle after the strobe
  task automatic read(input lgc_byte_t a, output lgc_byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : read

  // write, then read the same place back with no idle cycle between strobes
  task automatic write_read(input lgc_byte_t a, input lgc_byte_t d, output lgc_byte_t q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
    q = rdata;
  endtask : write_read

endmodule : lgc_host

// ==== bench/lgc_bank_tb.sv ====
// self-checking testbench of the configuration and pulse segment bank
module lgc_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lgc_pkg::*;

  localparam int NCH = 14;
  logic clk = 1'b0;
  logic rst_n;
  lgc_byte_t addr, wdata, rdata;
  logic wr, rd;
  logic [NCH-1:0] loss, lclk, dp, dn, rxp, rxn, txp, txn, aos;
  logic [4*NCH-1:0] segp;
  logic rfmt, srst_act, irq;
  int n_errors = 0;
  int num_checks = 0;

  // free running 125 MHz clock
  always #4 clk = ~clk;

  // line clocks and rails shared between receive and transmit pins
  lgc_bank #(.NUM_CH(NCH)) lgc_bank_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_loss_of_signal(loss), .rx_clock(lclk), .rx_pos_in(dp), .rx_neg_in(dn),
    .rx_pos_rail(rxp), .rx_neg_rail(rxn), .tx_line_clock(lclk), .tx_pos_rail(dp),
    .tx_neg_rail(dn), .tx_pos_data(txp), .tx_neg_data(txn), .tx_all_ones(aos),
    .seg_positive(segp), .rail_format_select(rfmt), .soft_reset_active(srst_act), .irq(irq)
  );

  lgc_host lgc_host_i (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input lgc_byte_t a, input lgc_byte_t exp);
    lgc_byte_t d;
    lgc_host_i.read(a, d);
    chk(64'(d), 64'(exp));
  endtask : rchk

  // one line clock phase, long enough to cross the synchronisers
  task automatic tick(input logic lvl);
    @(posedge clk);
    lclk <= {NCH{lvl}};
    repeat (8) @(posedge clk);
  endtask : tick

  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(8'he0, 8'h00);
    rchk(8'he1, 8'h00);
    chk(64'(rfmt), 64'h0);
    chk(64'(irq), 64'h0);
  endtask : t_reset

  // all segments of all channels, then two unmapped places
  task automatic t_segments;
    logic [4*NCH-1:0] sgn;
    lgc_byte_t v;
    for (int ch = 0; ch < NCH; ch++) begin
      for (int s = 0; s < 4; s++) begin
        v = 8'(ch * 9 + s * 37) | 8'h80;
        sgn[ch*4+s] = v[6];
        lgc_host_i.write(8'(ch * 16 + 12 + s), v);
      end
    end
    for (int ch = 0; ch < NCH; ch++) begin
      for (int s = 0; s < 4; s++) begin
        rchk(8'(ch * 16 + 12 + s), (8'(ch * 9 + s * 37)) & 8'h7f);
      end
    end
    chk(64'(segp), 64'(sgn));
    lgc_host_i.write_read(8'hdf, 8'hd3, v);
    chk(64'(v), 64'h53);
    lgc_host_i.write(8'hec, 8'h7f);
    rchk(8'hec, 8'h00);
    lgc_host_i.write(8'he2, 8'hff);
    rchk(8'he2, 8'h00);
  endtask : t_segments

  task automatic t_global;
    lgc_host_i.write(8'he0, 8'hfe);
    rchk(8'he0, 8'hfa);
    chk(64'(rfmt), 64'h1);
    lgc_host_i.write(8'he1, 8'hff);
    rchk(8'he1, 8'h04);
    lgc_host_i.write(8'he0, 8'h00);
    lgc_host_i.write(8'he1, 8'h00);
  endtask : t_global

  // data changes between the edges, so a rising-edge capture keeps b and a falling-edge capture keeps a
  task automatic t_edge(input bit tx, input bit sel);
    logic [NCH-1:0] a, b, e, ne;
    a = 14'h1555;
    b = 14'h2aaa;
    lgc_host_i.write(8'he0, tx ? {3'b000, sel, sel, 3'b000} : {2'b00, sel, 1'b0, sel, 3'b000});
    dp <= a;
    dn <= ~a;
    tick(1'b1);
    tick(1'b0);
    @(posedge clk);
    dp <= b;
    dn <= ~b;
    tick(1'b1);
    dp <= a;
    dn <= ~a;
    tick(1'b0);
    e = ((tx == sel) ? b : a) ^ {NCH{sel}};
    ne = ~e;
    chk(64'(tx ? txp : rxp), 64'(e));
    chk(64'(tx ? txn : rxn), 64'(ne));
  endtask : t_edge

  task automatic t_format_mute;
    lgc_host_i.write(8'he0, 8'h80);
    loss <= 14'h0001;
    lgc_host_i.write(8'he1, 8'h04);
    dp <= {NCH{1'b1}};
    dn <= {NCH{1'b1}};
    tick(1'b1);
    tick(1'b0);
    chk(64'(rxn), 64'h0);
    chk(64'(txn), 64'h0);
    chk(64'(rxp), 64'h3ffe);
    lgc_host_i.write(8'he1, 8'h00);
    tick(1'b1);
    tick(1'b0);
    chk(64'(rxp), 64'h3fff);
    loss <= 14'h0000;
    lgc_host_i.write(8'he0, 8'h00);
  endtask : t_format_mute

  // loss change on channel 2, first with the global gate shut
  task automatic t_irq;
    lgc_byte_t d;
    lgc_host_i.write(8'h24, 8'h02);
    repeat (8) @(posedge clk);
    lgc_host_i.read(8'h26, d);
    @(posedge clk);
    loss <= 14'h0004;
    repeat (8) @(posedge clk);
    chk(64'(irq), 64'h0);
    rchk(8'h26, 8'h02);
    rchk(8'h26, 8'h00);
    lgc_host_i.write(8'he0, 8'h02);
    loss <= 14'h0000;
    repeat (8) @(posedge clk);
    chk(64'(irq), 64'h1);
    rchk(8'h26, 8'h02);
    repeat (2) @(posedge clk);
    chk(64'(irq), 64'h0);
    lgc_host_i.write(8'h24, 8'h00);
    lgc_host_i.write(8'he0, 8'h00);
  endtask : t_irq

  task automatic t_soft_reset;
    loss <= 14'h0008;
    lgc_host_i.write(8'he0, 8'h40);
    repeat (8) @(posedge clk);
    chk(64'(aos), 64'h0008);
    lgc_host_i.write(8'he0, 8'h41);
    repeat (1240) @(posedge clk);
    chk(64'(srst_act), 64'h0);
    repeat (20) @(posedge clk);
    chk(64'(srst_act), 64'h1);
    chk(64'(aos), 64'h0);
    chk(64'(rxp), 64'h0);
    rchk(8'he0, 8'h41);
    lgc_host_i.write(8'he0, 8'h40);
    repeat (3) @(posedge clk);
    chk(64'(srst_act), 64'h0);
    repeat (4) @(posedge clk);
    chk(64'(aos), 64'h0008);
    lgc_host_i.write(8'he0, 8'h00);
    repeat (6) @(posedge clk);
    chk(64'(aos), 64'h0);
    loss <= 14'h0000;
  endtask : t_soft_reset

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    loss = '0;
    lclk = '0;
    dp = '0;
    dn = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_segments();
    t_global();
    for (int tx = 0; tx < 2; tx++) begin
      for (int sel = 0; sel < 2; sel++) begin
        t_edge(tx[0], sel[0]);
      end
    end
    t_format_mute();
    t_irq();
    t_soft_reset();
    print_verdict();
  end

  // cuts a hang short well after the expected run length
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

endmodule : lgc_bank_tb
